// ---- hw/isol_defs.svh ----
// register map, field positions, reset values and codes of the status-output block
`ifndef ISOL_DEFS_SVH
`define ISOL_DEFS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define ISOL_FREQ_W 16
`define ISOL_HOUR_W 20
`define ISOL_ADDR_W 6

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ISOL_OFS_SELECT 6'h00
`define ISOL_OFS_LOGIC 6'h04
`define ISOL_OFS_ACC_ARR 6'h08
`define ISOL_OFS_DEC_ARR 6'h0c
`define ISOL_OFS_ZS_LEVEL 6'h10
`define ISOL_OFS_WARN 6'h14
`define ISOL_OFS_STATE 6'h18
`define ISOL_OFS_IRQ_STAT 6'h1c
`define ISOL_OFS_IRQ_MASK 6'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ISOL_POS_TERM_SEL 0
`define ISOL_POS_RELAY_SEL 8
`define ISOL_POS_OPA_SEL 0
`define ISOL_POS_OPB_SEL 8
`define ISOL_POS_OPER 16
`define ISOL_POS_WARN_EXT 16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ISOL_RST_SEL 8'hff
`define ISOL_RST_OPER 2'h0
`define ISOL_RST_FREQ 16'h0000
`define ISOL_RST_WARN 14'h0000
`define ISOL_RST_MASK 7'h00

// ----------------------------------------------------------------
// selector codes (value of the decimal function code)
// ----------------------------------------------------------------
`define ISOL_CODE_RUN 8'h00
`define ISOL_CODE_FA1 8'h01
`define ISOL_CODE_FA2 8'h02
`define ISOL_CODE_FA3 8'h06
`define ISOL_CODE_RNT 8'h0b
`define ISOL_CODE_ONT 8'h0c
`define ISOL_CODE_ZS 8'h15
`define ISOL_CODE_LOG 8'h21
`define ISOL_CODE_MAXOP 8'h3c
`define ISOL_CODE_NONE 8'hff

// ----------------------------------------------------------------
// operators, hysteresis percentages, hour units
// ----------------------------------------------------------------
`define ISOL_OP_AND 2'h0
`define ISOL_OP_OR 2'h1
`define ISOL_OP_XOR 2'h2
`define ISOL_PCT_ON 8'h01
`define ISOL_PCT_OFF 8'h02
`define ISOL_UNIT_SHORT 20'h0000a
`define ISOL_UNIT_LONG 20'h00064

`endif

// ---- hw/isol_pkg.sv ----
// types shared by the status-output block
package isol_pkg;
  `include "isol_defs.svh"

  // one bit per indication, also the layout of state, irq status and mask
  typedef struct packed {
    logic zero_speed_detect;
    logic power_on_time_over;
    logic run_time_over;
    logic set_freq_reached_only;
    logic set_freq_overreached;
    logic const_speed_reached;
    logic running;
  } isol_ind_t;

  // software settings
  typedef struct packed {
    logic [7:0] terminal_function_select;
    logic [7:0] relay_function_select;
    logic [7:0] logic_operand_a_select;
    logic [7:0] logic_operand_b_select;
    logic [1:0] logic_operator_select;
    logic [`ISOL_FREQ_W-1:0] accel_arrival_threshold;
    logic [`ISOL_FREQ_W-1:0] decel_arrival_threshold;
    logic [`ISOL_FREQ_W-1:0] zero_speed_level;
    logic [13:0] warning_time_setting;
    logic warn_long_unit;
    isol_ind_t irq_mask;
  } isol_cfg_t;

  // whole state of the block
  typedef struct packed {
    isol_cfg_t cfg;
    isol_ind_t ind;
    isol_ind_t ind_prev;
    isol_ind_t irq_stat;
    logic logic_output_result;
    logic term_out;
    logic relay_out;
    logic ack;
    logic [31:0] rdata;
  } isol_state_t;
endpackage

// ---- hw/isol_top.sv ----
// status-output logic: indications, selectors, logic function, register slave
//
// Functional notes
// - running asserts while operating, DC brake included
// - terminal and relay each select one code
// - arrival codes 01, 02, 06
// - default arrival hysteresis: on -1%, off -2%
// - reached-only accelerating: on -1%, off +2%
// - reached-only decelerating: on +1%, off -2%
// - accel threshold zero disables arrival output
// - decel threshold zero disables arrival output
// - constant-speed reached tracks active target frequency
// - overreached uses accel or decel threshold
// - reached-only only near threshold, direction hysteresis
// - run/power-on time over codes 11, 12
// - warning time zero disables both
// - warning units 10 or 100 hours
// - zero speed below programmable level, code 21
// - logic result AND/OR/XOR of two operands
// - operands accept 00..60, exclude 33 and none
// - logic result routed by code 33
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module isol_top
  import isol_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // inverter state from control logic
  input wire logic [`ISOL_FREQ_W-1:0] OUT_FREQ,
  input wire logic [`ISOL_FREQ_W-1:0] TARGET_FREQ,
  input wire logic [`ISOL_FREQ_W-1:0] MAX_FREQ,
  input wire logic RUNNING,
  input wire logic ACCELERATING,
  input wire logic DECELERATING,
  input wire logic [`ISOL_HOUR_W-1:0] RUN_HOURS,
  input wire logic [`ISOL_HOUR_W-1:0] POWER_HOURS,
  // avalon-mm slave
  input wire logic [`ISOL_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // outputs to external equipment, and the interrupt request
  output logic TERM_OUT,
  output logic RELAY_OUT,
  output logic IRQ
);

  localparam int FW = `ISOL_FREQ_W;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // percentage of maximum frequency, kept one bit wider to hold sums
  function automatic logic [FW:0] pct(input logic [FW-1:0] m, input logic [7:0] n);
    logic [31:0] p;
    p = (32'(m) * 32'(n)) / 32'd100;
    return p[FW:0];
  endfunction

  // subtraction clamped at zero so a low target never wraps
  function automatic logic [FW:0] sub0(input logic [FW-1:0] a, input logic [FW:0] b);
    return ({1'b0, a} > b) ? ({1'b0, a} - b) : '0;
  endfunction

  // default arrival hysteresis around t
  function automatic logic hyst(input logic [FW:0] f, input logic [FW-1:0] t,
                                input logic [FW:0] on_w, input logic [FW:0] off_w,
                                input logic prev);
    logic r;
    r = prev;
    if (f >= sub0(t, on_w)) begin
      r = 1'b1;
    end else if (f < sub0(t, off_w)) begin
      r = 1'b0;
    end
    return r;
  endfunction

  // pick one indication by selector code; unknown codes give low
  function automatic logic pick(input logic [7:0] code, input isol_ind_t i, input logic lg);
    logic r;
    r = 1'b0;
    case (code)
      `ISOL_CODE_RUN: r = i.running;
      `ISOL_CODE_FA1: r = i.const_speed_reached;
      `ISOL_CODE_FA2: r = i.set_freq_overreached;
      `ISOL_CODE_FA3: r = i.set_freq_reached_only;
      `ISOL_CODE_RNT: r = i.run_time_over;
      `ISOL_CODE_ONT: r = i.power_on_time_over;
      `ISOL_CODE_ZS: r = i.zero_speed_detect;
      `ISOL_CODE_LOG: r = lg;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // operand pick: logic result and none excluded, range 00..60
  function automatic logic operand(input logic [7:0] code, input isol_ind_t i);
    logic r;
    r = 1'b0;
    if (code <= `ISOL_CODE_MAXOP && code != `ISOL_CODE_LOG) begin
      r = pick(code, i, 1'b0);
    end
    return r;
  endfunction

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  isol_state_t s_q;
  isol_state_t s_d;
  isol_ind_t ind_n;
  logic [FW:0] f_ext;
  logic [FW:0] on_w;
  logic [FW:0] off_w;
  logic [FW-1:0] arr_thr;
  logic [`ISOL_HOUR_W-1:0] warn_lim;
  logic req;
  logic take;
  logic [31:0] rd_n;
  logic [31:0] sel_word;
  logic [31:0] logic_word;
  logic [31:0] warn_word;
  logic [31:0] wr_word;
  logic opa;
  logic opb;
  logic lg_n;

  // ----------------------------------------------------------------
  // indication evaluation, once per clock
  // ----------------------------------------------------------------

  // hysteresis widths; overreached follows the threshold of the current ramp
  always_comb begin
    f_ext = {1'b0, OUT_FREQ};
    on_w = pct(MAX_FREQ, `ISOL_PCT_ON);
    off_w = pct(MAX_FREQ, `ISOL_PCT_OFF);
    arr_thr = DECELERATING ? s_q.cfg.decel_arrival_threshold : s_q.cfg.accel_arrival_threshold;
    if (s_q.cfg.warn_long_unit) begin
      warn_lim = 20'(s_q.cfg.warning_time_setting) * `ISOL_UNIT_LONG;
    end else begin
      warn_lim = 20'(s_q.cfg.warning_time_setting) * `ISOL_UNIT_SHORT;
    end
  end

  // next value of each indication
  always_comb begin
    ind_n = s_q.ind;
    ind_n.running = RUNNING;
    // constant speed: the control logic delivers the active target
    ind_n.const_speed_reached = RUNNING &&
      hyst(f_ext, TARGET_FREQ, on_w, off_w, s_q.ind.const_speed_reached);
    // threshold of zero switches the arrival output off entirely
    if (arr_thr == '0) begin
      ind_n.set_freq_overreached = 1'b0;
    end else begin
      ind_n.set_freq_overreached = RUNNING &&
        hyst(f_ext, arr_thr, on_w, off_w, s_q.ind.set_freq_overreached);
    end
    // reached-only: a window around the threshold, edges depend on ramp
    if (!RUNNING) begin
      ind_n.set_freq_reached_only = 1'b0;
    end else if (ACCELERATING) begin
      if (s_q.cfg.accel_arrival_threshold == '0) begin
        ind_n.set_freq_reached_only = 1'b0;
      end else if (f_ext >= {1'b0, s_q.cfg.accel_arrival_threshold} + off_w) begin
        ind_n.set_freq_reached_only = 1'b0;
      end else if (f_ext >= sub0(s_q.cfg.accel_arrival_threshold, on_w)) begin
        ind_n.set_freq_reached_only = 1'b1;
      end
    end else if (DECELERATING) begin
      if (s_q.cfg.decel_arrival_threshold == '0) begin
        ind_n.set_freq_reached_only = 1'b0;
      end else if (f_ext <= sub0(s_q.cfg.decel_arrival_threshold, off_w)) begin
        ind_n.set_freq_reached_only = 1'b0;
      end else if (f_ext <= {1'b0, s_q.cfg.decel_arrival_threshold} + on_w) begin
        ind_n.set_freq_reached_only = 1'b1;
      end
    end
    // time-over warnings; zero setting keeps both low
    ind_n.run_time_over = (s_q.cfg.warning_time_setting != '0) && (RUN_HOURS > warn_lim);
    ind_n.power_on_time_over = (s_q.cfg.warning_time_setting != '0) && (POWER_HOURS > warn_lim);
    ind_n.zero_speed_detect = OUT_FREQ < s_q.cfg.zero_speed_level;
  end

  // two-operand logic function works on registered indications
  always_comb begin
    opa = operand(s_q.cfg.logic_operand_a_select, s_q.ind);
    opb = operand(s_q.cfg.logic_operand_b_select, s_q.ind);
    case (s_q.cfg.logic_operator_select)
      `ISOL_OP_AND: lg_n = opa & opb;
      `ISOL_OP_OR: lg_n = opa | opb;
      `ISOL_OP_XOR: lg_n = opa ^ opb;
      default: lg_n = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------

  // one wait state: read data is latched while waitrequest is high
  assign req = AVS_READ | AVS_WRITE;
  assign take = req & s_q.ack;
  assign AVS_WAITREQUEST = req & ~s_q.ack;

  // packed images of the settings registers
  always_comb begin
    sel_word = '0;
    sel_word[`ISOL_POS_TERM_SEL +: 8] = s_q.cfg.terminal_function_select;
    sel_word[`ISOL_POS_RELAY_SEL +: 8] = s_q.cfg.relay_function_select;
    logic_word = '0;
    logic_word[`ISOL_POS_OPA_SEL +: 8] = s_q.cfg.logic_operand_a_select;
    logic_word[`ISOL_POS_OPB_SEL +: 8] = s_q.cfg.logic_operand_b_select;
    logic_word[`ISOL_POS_OPER +: 2] = s_q.cfg.logic_operator_select;
    warn_word = '0;
    warn_word[13:0] = s_q.cfg.warning_time_setting;
    warn_word[`ISOL_POS_WARN_EXT] = s_q.cfg.warn_long_unit;
  end

  // read decode; unmapped addresses read zero
  always_comb begin
    rd_n = '0;
    if (AVS_ADDRESS == `ISOL_OFS_SELECT) begin
      rd_n = sel_word;
    end else if (AVS_ADDRESS == `ISOL_OFS_LOGIC) begin
      rd_n = logic_word;
    end else if (AVS_ADDRESS == `ISOL_OFS_ACC_ARR) begin
      rd_n[FW-1:0] = s_q.cfg.accel_arrival_threshold;
    end else if (AVS_ADDRESS == `ISOL_OFS_DEC_ARR) begin
      rd_n[FW-1:0] = s_q.cfg.decel_arrival_threshold;
    end else if (AVS_ADDRESS == `ISOL_OFS_ZS_LEVEL) begin
      rd_n[FW-1:0] = s_q.cfg.zero_speed_level;
    end else if (AVS_ADDRESS == `ISOL_OFS_WARN) begin
      rd_n = warn_word;
    end else if (AVS_ADDRESS == `ISOL_OFS_STATE) begin
      rd_n[6:0] = s_q.ind;
      rd_n[7] = s_q.logic_output_result;
    end else if (AVS_ADDRESS == `ISOL_OFS_IRQ_STAT) begin
      rd_n[6:0] = s_q.irq_stat;
    end else if (AVS_ADDRESS == `ISOL_OFS_IRQ_MASK) begin
      rd_n[6:0] = s_q.cfg.irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    wr_word = '0;
    s_d.ack = AVS_WAITREQUEST;
    if (AVS_READ && !s_q.ack) begin
      s_d.rdata = rd_n;
    end
    s_d.ind = ind_n;
    s_d.ind_prev = s_q.ind;
    s_d.logic_output_result = lg_n;
    // outputs come only from registered indications
    s_d.term_out = pick(s_q.cfg.terminal_function_select, s_q.ind, s_q.logic_output_result);
    s_d.relay_out = pick(s_q.cfg.relay_function_select, s_q.ind, s_q.logic_output_result);
    // read clears only the bits latched into read data one cycle earlier;
    // clearing all would lose an edge that lands between latch and take
    if (take && AVS_READ && AVS_ADDRESS == `ISOL_OFS_IRQ_STAT) begin
      s_d.irq_stat = s_q.irq_stat & ~s_q.rdata[6:0];
    end
    s_d.irq_stat = s_d.irq_stat | (s_q.ind & ~s_q.ind_prev);
    if (take && AVS_WRITE) begin
      if (AVS_ADDRESS == `ISOL_OFS_SELECT) begin
        wr_word = merge(sel_word, AVS_WRITEDATA, AVS_BYTEENABLE);
        s_d.cfg.terminal_function_select = wr_word[`ISOL_POS_TERM_SEL +: 8];
        s_d.cfg.relay_function_select = wr_word[`ISOL_POS_RELAY_SEL +: 8];
      end else if (AVS_ADDRESS == `ISOL_OFS_LOGIC) begin
        wr_word = merge(logic_word, AVS_WRITEDATA, AVS_BYTEENABLE);
        s_d.cfg.logic_operand_a_select = wr_word[`ISOL_POS_OPA_SEL +: 8];
        s_d.cfg.logic_operand_b_select = wr_word[`ISOL_POS_OPB_SEL +: 8];
        s_d.cfg.logic_operator_select = wr_word[`ISOL_POS_OPER +: 2];
      end else if (AVS_ADDRESS == `ISOL_OFS_ACC_ARR) begin
        wr_word = merge(32'(s_q.cfg.accel_arrival_threshold), AVS_WRITEDATA, AVS_BYTEENABLE);
        s_d.cfg.accel_arrival_threshold = wr_word[FW-1:0];
      end else if (AVS_ADDRESS == `ISOL_OFS_DEC_ARR) begin
        wr_word = merge(32'(s_q.cfg.decel_arrival_threshold), AVS_WRITEDATA, AVS_BYTEENABLE);
        s_d.cfg.decel_arrival_threshold = wr_word[FW-1:0];
      end else if (AVS_ADDRESS == `ISOL_OFS_ZS_LEVEL) begin
        wr_word = merge(32'(s_q.cfg.zero_speed_level), AVS_WRITEDATA, AVS_BYTEENABLE);
        s_d.cfg.zero_speed_level = wr_word[FW-1:0];
      end else if (AVS_ADDRESS == `ISOL_OFS_WARN) begin
        wr_word = merge(warn_word, AVS_WRITEDATA, AVS_BYTEENABLE);
        s_d.cfg.warning_time_setting = wr_word[13:0];
        s_d.cfg.warn_long_unit = wr_word[`ISOL_POS_WARN_EXT];
      end else if (AVS_ADDRESS == `ISOL_OFS_IRQ_MASK) begin
        wr_word = merge(32'(s_q.cfg.irq_mask), AVS_WRITEDATA, AVS_BYTEENABLE);
        s_d.cfg.irq_mask = wr_word[6:0];
      end
    end
  end

  // single state register
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      s_q <= '0;
      s_q.cfg.terminal_function_select <= `ISOL_RST_SEL;
      s_q.cfg.relay_function_select <= `ISOL_RST_SEL;
      s_q.cfg.logic_operand_a_select <= `ISOL_RST_SEL;
      s_q.cfg.logic_operand_b_select <= `ISOL_RST_SEL;
      s_q.cfg.logic_operator_select <= `ISOL_RST_OPER;
      s_q.cfg.accel_arrival_threshold <= `ISOL_RST_FREQ;
      s_q.cfg.decel_arrival_threshold <= `ISOL_RST_FREQ;
      s_q.cfg.zero_speed_level <= `ISOL_RST_FREQ;
      s_q.cfg.warning_time_setting <= `ISOL_RST_WARN;
      s_q.cfg.irq_mask <= `ISOL_RST_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign AVS_READDATA = s_q.rdata;
  assign TERM_OUT = s_q.term_out;
  assign RELAY_OUT = s_q.relay_out;
  assign IRQ = |(s_q.irq_stat & s_q.cfg.irq_mask);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  a_run_follows: assert property (RUNNING |=> s_q.ind.running)
    else $error("running indication missed");
  a_term_route: assert property (s_q.cfg.terminal_function_select == `ISOL_CODE_RUN
    && $stable(s_q.cfg.terminal_function_select) |=> TERM_OUT == $past(s_q.ind.running))
    else $error("terminal does not follow running");
  a_relay_zs: assert property (s_q.cfg.relay_function_select == `ISOL_CODE_ZS
    && $stable(s_q.cfg.relay_function_select) |=> RELAY_OUT == $past(s_q.ind.zero_speed_detect))
    else $error("relay does not follow zero speed");
  a_fa1_on: assert property (RUNNING && f_ext >= sub0(TARGET_FREQ, on_w)
    |=> s_q.ind.const_speed_reached)
    else $error("constant speed did not turn on");
  a_fa1_off: assert property (f_ext < sub0(TARGET_FREQ, off_w) && f_ext < sub0(TARGET_FREQ, on_w)
    |=> !s_q.ind.const_speed_reached)
    else $error("constant speed did not turn off");
  a_fa3_acc_off: assert property (RUNNING && ACCELERATING
    && f_ext >= {1'b0, s_q.cfg.accel_arrival_threshold} + off_w |=> !s_q.ind.set_freq_reached_only)
    else $error("reached-only stayed on past threshold");
  a_fa3_dec_on: assert property (RUNNING && DECELERATING && !ACCELERATING
    && s_q.cfg.decel_arrival_threshold != '0 && f_ext > sub0(s_q.cfg.decel_arrival_threshold, off_w)
    && f_ext <= {1'b0, s_q.cfg.decel_arrival_threshold} + on_w |=> s_q.ind.set_freq_reached_only)
    else $error("reached-only missed decel window");
  a_arr_off: assert property (arr_thr == '0 |=> !s_q.ind.set_freq_overreached)
    else $error("overreached with disabled threshold");
  a_warn_zero: assert property (s_q.cfg.warning_time_setting == '0
    |=> !s_q.ind.run_time_over && !s_q.ind.power_on_time_over)
    else $error("time over with zero setting");
  a_zs_level: assert property (OUT_FREQ < s_q.cfg.zero_speed_level && $stable(s_q.cfg.zero_speed_level)
    |=> s_q.ind.zero_speed_detect)
    else $error("zero speed missed");
  a_logic_and: assert property (s_q.cfg.logic_operator_select == `ISOL_OP_AND && $stable(s_q.cfg)
    && !(opa && opb) |=> !s_q.logic_output_result)
    else $error("and result wrong");
  a_irq_sticky: assert property ($rose(s_q.ind.zero_speed_detect) |=> s_q.irq_stat.zero_speed_detect)
    else $error("zero speed event not latched");
  a_bus_wait: assert property (req && !s_q.ack |=> !AVS_WAITREQUEST || !req)
    else $error("waitrequest held too long");

  c_log_route: cover property (TERM_OUT && s_q.cfg.terminal_function_select == `ISOL_CODE_LOG);
  c_fa3_acc: cover property (ACCELERATING && s_q.ind.set_freq_reached_only);
  c_rnt_on: cover property (s_q.ind.run_time_over);
  c_irq: cover property (IRQ);
endmodule

// ---- tb/isol_equip.sv ----
// model of the external equipment that reads the terminal and relay outputs
`timescale 1ns/1ps
module isol_equip (
  // clock
  input wire logic clk,
  // inverter outputs
  input wire logic term_in,
  input wire logic relay_in,
  // levels last seen by the equipment
  output logic term_seen,
  output logic relay_seen
);
  // ----------------------------------------
  // input scan
  // ----------------------------------------
  // read once a clock, like a controller input scan, so a glitch between edges is never seen
  always_ff @(posedge clk) begin
    term_seen <= term_in;
    relay_seen <= relay_in;
  end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the status-output block
`timescale 1ns/1ps
module tb_top;
  import isol_pkg::*;
  // ----------------------------------------
  // stimulus settings
  // ----------------------------------------
  localparam int MAXF = 12000;
  localparam int TF = 6000;
  localparam int P1 = MAXF / 100;
  localparam int P2 = 2 * MAXF / 100;
  localparam int ACC = 5000;
  localparam int DEC = 3000;
  // one case: selector, frequency, run/accel/decel, hours, expected output level
  typedef struct packed {
    logic [7:0] sel;
    logic [15:0] f;
    logic [2:0] rad;
    logic [19:0] h;
    logic exp;
  } isol_row_t;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] out_freq = 16'h0000;
  logic [15:0] tgt = 16'(TF);
  logic running = 1'b0;
  logic accel = 1'b0;
  logic decel = 1'b0;
  logic [19:0] run_hours = 20'h00000;
  logic [19:0] power_hours = 20'h00000;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] readdata, rd_s;
  logic waitreq, wreq_s, term_out, relay_out, irq, term_seen, relay_seen;
  int miscompares = 0;
  int total_checks = 0;
  // selector cases run in order; only the TF-P1-40 row leans on the state left by the one above
  isol_row_t rows [16] = '{
    '{8'h00, 16'(TF), 3'b100, 20'd0, 1'b1},
    '{8'h00, 16'(TF), 3'b000, 20'd0, 1'b0},
    '{8'h01, 16'(TF-P1), 3'b100, 20'd0, 1'b1},
    '{8'h01, 16'(TF-P1-40), 3'b100, 20'd0, 1'b1},
    '{8'h01, 16'(TF-P2-1), 3'b100, 20'd0, 1'b0},
    '{8'h02, 16'(ACC+1), 3'b110, 20'd0, 1'b1},
    '{8'h02, 16'(ACC-P2-60), 3'b110, 20'd0, 1'b0},
    '{8'h06, 16'(ACC-P1), 3'b110, 20'd0, 1'b1},
    '{8'h06, 16'(ACC+P2+1), 3'b110, 20'd0, 1'b0},
    '{8'h06, 16'(DEC+P1), 3'b101, 20'd0, 1'b1},
    '{8'h06, 16'(DEC-P2-1), 3'b101, 20'd0, 1'b0},
    '{8'h15, 16'd50, 3'b100, 20'd0, 1'b1},
    '{8'h15, 16'd100, 3'b100, 20'd0, 1'b0},
    '{8'h0b, 16'(TF), 3'b100, 20'd51, 1'b1},
    '{8'h0b, 16'(TF), 3'b100, 20'd50, 1'b0},
    '{8'h0c, 16'(TF), 3'b100, 20'd51, 1'b1}
  };

  isol_top i_isol_top (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .OUT_FREQ(out_freq), .TARGET_FREQ(tgt),
    .MAX_FREQ(16'(MAXF)), .RUNNING(running), .ACCELERATING(accel), .DECELERATING(decel),
    .RUN_HOURS(run_hours), .POWER_HOURS(power_hours), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(readdata), .AVS_WAITREQUEST(waitreq), .TERM_OUT(term_out), .RELAY_OUT(relay_out), .IRQ(irq));
  isol_equip i_isol_equip (.clk(clk_sys), .term_in(term_out), .relay_in(relay_out),
    .term_seen(term_seen), .relay_seen(relay_seen));

  // ----------------------------------------
  // clock, bus sampling, watchdog
  // ----------------------------------------
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // answer settles mid-cycle; the value held here is what the next rising edge sees
  always @(negedge clk_sys) begin
    wreq_s = waitreq;
    rd_s = readdata;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic complete_run();
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wreq_s !== 1'b0 && n < 20);
    q = rd_s;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic apply(input isol_row_t r);
    logic [31:0] q;
    bus(1'b1, `ISOL_OFS_SELECT, {16'h0, r.sel, r.sel}, q);
    out_freq <= r.f;
    {running, accel, decel} <= r.rad;
    run_hours <= r.h;
    power_hours <= r.h;
    repeat (5) @(posedge clk_sys);
    chk("term_out", {31'h0, r.exp}, {31'h0, term_seen});
    chk("relay_out", {31'h0, r.exp}, {31'h0, relay_seen});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    bus(1'b0, `ISOL_OFS_SELECT, 32'h0, q);
    chk("select_rst", 32'h0000ffff, q);
    bus(1'b0, 6'h24, 32'h0, q);
    chk("unmapped", 32'h0, q);
    bus(1'b1, `ISOL_OFS_ACC_ARR, 32'(ACC), q);
    bus(1'b1, `ISOL_OFS_DEC_ARR, 32'(DEC), q);
    bus(1'b1, `ISOL_OFS_ZS_LEVEL, 32'd100, q);
    bus(1'b1, `ISOL_OFS_WARN, 32'd5, q);
    foreach (rows[i]) apply(rows[i]);
    // long hour unit: setting 1 means 100 hours
    bus(1'b1, `ISOL_OFS_WARN, 32'h00010001, q);
    apply('{8'h0b, 16'(TF), 3'b100, 20'd101, 1'b1});
    apply('{8'h0b, 16'(TF), 3'b100, 20'd100, 1'b0});
    // constant speed follows a moved target
    apply('{8'h01, 16'(DEC), 3'b100, 20'd0, 1'b0});
    tgt <= 16'(DEC);
    apply('{8'h01, 16'(DEC), 3'b100, 20'd0, 1'b1});
    tgt <= 16'(TF);
    // logic function: running=1 against zero speed=0 under every operator
    apply('{8'h21, 16'(TF), 3'b100, 20'd0, 1'b0});
    for (int op = 0; op < 4; op++) begin
      bus(1'b1, `ISOL_OFS_LOGIC, {14'h0, op[1:0], 8'h15, 8'h00}, q);
      repeat (6) @(posedge clk_sys);
      chk("logic_out", {31'h0, op == 1 || op == 2}, {31'h0, term_seen});
    end
    // own result as operand counts as low: low xor running gives high
    bus(1'b1, `ISOL_OFS_LOGIC, {14'h0, 2'h2, 8'h00, 8'h21}, q);
    repeat (6) @(posedge clk_sys);
    chk("logic_self", 32'h1, {31'h0, term_seen});
    bus(1'b1, `ISOL_OFS_ACC_ARR, 32'h0, q);
    bus(1'b1, `ISOL_OFS_WARN, 32'h0, q);
    apply('{8'h02, 16'(ACC+1), 3'b110, 20'd0, 1'b0});
    apply('{8'h0b, 16'(TF), 3'b100, 20'd51, 1'b0});
    // interrupt: zero speed unmasked, status read clears it
    bus(1'b1, `ISOL_OFS_IRQ_MASK, 32'h40, q);
    bus(1'b0, `ISOL_OFS_IRQ_STAT, 32'h0, q);
    apply('{8'h15, 16'd50, 3'b100, 20'd0, 1'b1});
    chk("irq_set", 32'h1, {31'h0, irq});
    bus(1'b0, `ISOL_OFS_IRQ_STAT, 32'h0, q);
    chk("irq_stat", 32'h40, q);
    @(posedge clk_sys);
    chk("irq_clr", 32'h0, {31'h0, irq});
    // reset in mid-run: terminal output and irq low, mask back to zero
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("rst_term", 32'h0, {31'h0, term_out});
    chk("rst_irq", 32'h0, {31'h0, irq});
    sys_rst <= 1'b0;
    bus(1'b0, `ISOL_OFS_IRQ_MASK, 32'h0, q);
    chk("rst_mask", 32'h0, q);
    complete_run();
  end
endmodule
